// ===== src/fspcu_regs.vh
/*
 Register map, command codes, array port encodings and constants of the
 flash self-programming command unit.
 Assumes inclusion by bare name from the design file.
*/
`ifndef FSPCU_REGS_VH
`define FSPCU_REGS_VH

// Register byte offsets
`define FSPCU_OFS_CMD 8'h00
`define FSPCU_OFS_CTRLA 8'h04
`define FSPCU_OFS_CCP 8'h08
`define FSPCU_OFS_ADDR 8'h0C
`define FSPCU_OFS_DATA 8'h10
`define FSPCU_OFS_STATUS 8'h14

// Field positions
`define FSPCU_CTRLA_EXEC 0
`define FSPCU_ST_BUSY 0
`define FSPCU_ST_FLASH_SECTION_BUSY 1
`define FSPCU_ST_ABORT 2

// Protection key, value arbitrary
`define FSPCU_CCP_KEY 8'hC3

// Command codes
`define FSPCU_CMD_NOP 7'h00
`define FSPCU_CMD_READ_USER 7'h01
`define FSPCU_CMD_READ_PROD 7'h02
`define FSPCU_CMD_ERASE_USIG 7'h18
`define FSPCU_CMD_WRITE_USIG 7'h1A
`define FSPCU_CMD_ERASE_APP 7'h20
`define FSPCU_CMD_ERASE_APP_PG 7'h22
`define FSPCU_CMD_LOAD_BUF 7'h23
`define FSPCU_CMD_WRITE_APP_PG 7'h24
`define FSPCU_CMD_ERWR_APP_PG 7'h25
`define FSPCU_CMD_CLEAR_BUF 7'h26
`define FSPCU_CMD_ERASE_PG 7'h2B
`define FSPCU_CMD_WRITE_BOOT_PG 7'h2C
`define FSPCU_CMD_ERWR_BOOT_PG 7'h2D
`define FSPCU_CMD_WRITE_PG 7'h2E
`define FSPCU_CMD_ERWR_PG 7'h2F
`define FSPCU_CMD_APPLICATION_CHECKSUM_CMD 7'h38
`define FSPCU_CMD_BOOT_CRC 7'h39
`define FSPCU_CMD_RANGE_CRC 7'h3A

// Array port operations and spaces
`define FSPCU_OP_READ 3'h0
`define FSPCU_OP_WRITE 3'h1
`define FSPCU_OP_ERASE_PG 3'h2
`define FSPCU_OP_ERASE_APP 3'h3
`define FSPCU_OP_ERASE_SIG 3'h4
`define FSPCU_SP_FLASH 2'h0
`define FSPCU_SP_USER 2'h1
`define FSPCU_SP_PROD 2'h2

// Data constants
`define FSPCU_ERASED 16'hFFFF
`define FSPCU_CRC_POLY 16'h1021
`define FSPCU_CRC_INIT 16'hFFFF

`endif

// ===== src/fspcu_top.v
/*
 Flash self-programming command unit: command register, protection window,
 page buffer, page erase/write sequencing, section and range checksums,
 signature row access, busy and CPU halt reporting, Avalon-MM slave.
 Assumes the core holds its byte-read and store requests as one-cycle pulses
 with the pointer valid in the same cycle, and an array that completes each
 presented operation with a one-cycle fl_done.
*/
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fspcu_regs.vh"

module fspcu_top #(
  parameter ADDR_W = 16,
  parameter PW_LOG2 = 6,
  parameter BOOT_START_PAGE = 480,
  parameter [3:0] CCP_WINDOW = 4'h4
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Core side
  input wire [ADDR_W-1:0] z_pointer,
  input wire [15:0] word_data_registers,
  input wire program_memory_byte_read,
  input wire program_memory_store,
  input wire boot_lock_programmed,
  output reg [7:0] byte_read_data,
  output reg byte_read_valid,
  output reg cpu_halt,
  output wire nvm_busy,
  output wire flash_section_busy,
  output wire app_access_blocked,
  // Flash array port
  output reg fl_valid,
  output reg [2:0] fl_op,
  output reg [1:0] fl_space,
  output reg [ADDR_W-2:0] fl_addr,
  output reg [15:0] fl_wdata,
  input wire fl_done,
  input wire [15:0] fl_rdata
);

  localparam PAGE_W = ADDR_W - 1 - PW_LOG2;
  localparam PAGE_WORDS = 1 << PW_LOG2;
  localparam [PAGE_W-1:0] BOOT_PG = BOOT_START_PAGE;
  localparam [ADDR_W-2:0] BOOT_WORD = {BOOT_PG, {PW_LOG2{1'b0}}};
  localparam [ADDR_W-2:0] TOP_WORD = {(ADDR_W-1){1'b1}};
  localparam [PW_LOG2-1:0] LAST_IDX = {PW_LOG2{1'b1}};

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_READ = 3'h1;
  localparam [2:0] ST_CLEAR = 3'h2;
  localparam [2:0] ST_ERASE = 3'h3;
  localparam [2:0] ST_WRITE = 3'h4;
  localparam [2:0] ST_CRC = 3'h5;
  localparam [2:0] ST_POSTCLR = 3'h6;

  reg [2:0] state;
  reg bus_ack;
  reg [6:0] cmd_sel;
  reg [23:0] nvm_addr;
  reg [23:0] nvm_data;
  reg abort_flag;
  reg [3:0] ccp_cnt;
  reg [PAGE_W-1:0] op_page;
  reg [PW_LOG2-1:0] widx;
  reg write_after;
  reg post_clear;
  reg byte_sel;
  reg range_lock;
  reg [ADDR_W-2:0] crc_end;
  reg [15:0] crc_val;
  reg [31:0] rd_mux;

  wire [PAGE_W-1:0] z_page = z_pointer[ADDR_W-1:PW_LOG2+1];
  wire [PW_LOG2-1:0] z_word = z_pointer[PW_LOG2:1];
  wire z_boot = z_page >= BOOT_PG;
  wire idle = state == ST_IDLE;
  wire ccp_open = ccp_cnt != 4'h0;
  wire busy = !(idle || state == ST_READ);
  wire bus_req = avs_read | avs_write;
  wire wr_go = avs_write & bus_ack;
  wire wr_ctrla = wr_go && avs_address == `FSPCU_OFS_CTRLA && avs_byteenable[0];
  // Only the buffer load is accepted outside the protection window
  wire store_go = program_memory_store && idle &&
                  (cmd_sel == `FSPCU_CMD_LOAD_BUF || ccp_open);
  wire exec_go = wr_ctrla && avs_writedata[`FSPCU_CTRLA_EXEC] && ccp_open && idle;
  wire buf_load = store_go && cmd_sel == `FSPCU_CMD_LOAD_BUF;
  wire buf_clear = state == ST_CLEAR || state == ST_POSTCLR;
  wire [ADDR_W-2:0] crc_next = fl_addr + 1'b1;
  wire [PW_LOG2-1:0] widx_next = widx + 1'b1;
  wire [PAGE_WORDS*16-1:0] buf_flat;

  assign avs_waitrequest = bus_req & ~bus_ack;
  assign nvm_busy = busy;
  assign flash_section_busy = state == ST_ERASE || state == ST_WRITE;
  assign app_access_blocked = flash_section_busy;

  genvar g;
  generate
    for (g = 0; g < PAGE_WORDS; g = g + 1) begin : gen_buf
      localparam [PW_LOG2-1:0] IDX = g;
      reg [15:0] word;
      reg loaded;
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          word <= `FSPCU_ERASED;
          loaded <= 1'b0;
        end else if (buf_clear) begin
          loaded <= 1'b0;
        end else if (buf_load && z_word == IDX) begin
          word <= word_data_registers;
          loaded <= 1'b1;
        end
      end
      assign buf_flat[g*16 +: 16] = loaded ? word : `FSPCU_ERASED;
    end
  endgenerate

  function [15:0] crc16_word;
    input [15:0] c;
    input [15:0] d;
    integer i;
    reg [15:0] r;
    begin
      r = c;
      for (i = 15; i >= 0; i = i - 1) begin
        r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `FSPCU_CRC_POLY) : {r[14:0], 1'b0};
      end
      crc16_word = r;
    end
  endfunction

  function [23:0] merge24;
    input [23:0] old;
    input [31:0] nw;
    input [3:0] be;
    begin
      merge24[7:0] = be[0] ? nw[7:0] : old[7:0];
      merge24[15:8] = be[1] ? nw[15:8] : old[15:8];
      merge24[23:16] = be[2] ? nw[23:16] : old[23:16];
    end
  endfunction

  always @* begin
    case (avs_address)
      `FSPCU_OFS_CMD: rd_mux = {25'h000_0000, cmd_sel};
      `FSPCU_OFS_CTRLA: rd_mux = 32'h0000_0000;
      `FSPCU_OFS_CCP: rd_mux = {31'h0000_0000, ccp_open};
      `FSPCU_OFS_ADDR: rd_mux = {8'h00, nvm_addr};
      `FSPCU_OFS_DATA: rd_mux = {8'h00, nvm_data};
      `FSPCU_OFS_STATUS: rd_mux = {29'h0000_0000, abort_flag, flash_section_busy, busy};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (avs_read && !bus_ack) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Array operations start through this task so valid, op, space, start address and next state are set together
  task launch;
    input [2:0] op;
    input [1:0] sp;
    input [ADDR_W-2:0] a;
    input [2:0] st;
    begin
      fl_valid <= 1'b1;
      fl_op <= op;
      fl_space <= sp;
      fl_addr <= a;
      state <= st;
    end
  endtask

  task finish;
    begin
      fl_valid <= 1'b0;
      cpu_halt <= 1'b0;
      state <= ST_IDLE;
    end
  endtask

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cmd_sel <= `FSPCU_CMD_NOP;
      nvm_addr <= 24'h00_0000;
      nvm_data <= 24'h00_0000;
      abort_flag <= 1'b0;
      ccp_cnt <= 4'h0;
      op_page <= {PAGE_W{1'b0}};
      widx <= {PW_LOG2{1'b0}};
      write_after <= 1'b0;
      post_clear <= 1'b0;
      byte_sel <= 1'b0;
      range_lock <= 1'b0;
      crc_end <= {(ADDR_W-1){1'b0}};
      crc_val <= `FSPCU_CRC_INIT;
      byte_read_data <= 8'h00;
      byte_read_valid <= 1'b0;
      cpu_halt <= 1'b0;
      fl_valid <= 1'b0;
      fl_op <= `FSPCU_OP_READ;
      fl_space <= `FSPCU_SP_FLASH;
      fl_addr <= {(ADDR_W-1){1'b0}};
      fl_wdata <= `FSPCU_ERASED;
    end else begin
      byte_read_valid <= 1'b0;
      // Register writes; hardware results below take priority
      if (wr_go && avs_address == `FSPCU_OFS_CMD && avs_byteenable[0]) begin
        cmd_sel <= avs_writedata[6:0];
      end
      if (wr_go && avs_address == `FSPCU_OFS_ADDR) begin
        nvm_addr <= merge24(nvm_addr, avs_writedata, avs_byteenable);
      end
      if (wr_go && avs_address == `FSPCU_OFS_DATA) begin
        nvm_data <= merge24(nvm_data, avs_writedata, avs_byteenable);
      end
      if (wr_go && avs_address == `FSPCU_OFS_STATUS && avs_byteenable[0] &&
          avs_writedata[`FSPCU_ST_ABORT]) begin
        abort_flag <= 1'b0;
      end
      if (wr_go && avs_address == `FSPCU_OFS_CCP && avs_byteenable[0] &&
          avs_writedata[7:0] == `FSPCU_CCP_KEY) begin
        ccp_cnt <= CCP_WINDOW;
      end else if (store_go || exec_go) begin
        ccp_cnt <= 4'h0;
      end else if (ccp_open) begin
        ccp_cnt <= ccp_cnt - 4'h1;
      end
      case (state)
        ST_IDLE: begin
          if (program_memory_byte_read) begin
            byte_sel <= z_pointer[0];
            if (cmd_sel == `FSPCU_CMD_READ_USER) begin
              launch(`FSPCU_OP_READ, `FSPCU_SP_USER, z_pointer[ADDR_W-1:1], ST_READ);
            end else if (cmd_sel == `FSPCU_CMD_READ_PROD) begin
              launch(`FSPCU_OP_READ, `FSPCU_SP_PROD, z_pointer[ADDR_W-1:1], ST_READ);
            end else begin
              launch(`FSPCU_OP_READ, `FSPCU_SP_FLASH, z_pointer[ADDR_W-1:1], ST_READ);
            end
          end else if (store_go) begin
            op_page <= z_page;
            widx <= {PW_LOG2{1'b0}};
            fl_wdata <= buf_flat[15:0];
            write_after <= 1'b0;
            post_clear <= 1'b0;
            case (cmd_sel)
              `FSPCU_CMD_ERASE_PG: begin
                cpu_halt <= z_boot;
                launch(`FSPCU_OP_ERASE_PG, `FSPCU_SP_FLASH, {z_page, LAST_IDX ^ LAST_IDX}, ST_ERASE);
              end
              `FSPCU_CMD_WRITE_PG: begin
                cpu_halt <= z_boot;
                launch(`FSPCU_OP_WRITE, `FSPCU_SP_FLASH, {z_page, LAST_IDX ^ LAST_IDX}, ST_WRITE);
              end
              `FSPCU_CMD_ERWR_PG: begin
                cpu_halt <= z_boot;
                write_after <= 1'b1;
                launch(`FSPCU_OP_ERASE_PG, `FSPCU_SP_FLASH, {z_page, LAST_IDX ^ LAST_IDX}, ST_ERASE);
              end
              `FSPCU_CMD_ERASE_APP_PG, `FSPCU_CMD_WRITE_APP_PG, `FSPCU_CMD_ERWR_APP_PG: begin
                // A page outside the application section aborts without busy
                if (z_boot) begin
                  abort_flag <= 1'b1;
                end else begin
                  write_after <= cmd_sel == `FSPCU_CMD_ERWR_APP_PG;
                  if (cmd_sel == `FSPCU_CMD_WRITE_APP_PG) begin
                    launch(`FSPCU_OP_WRITE, `FSPCU_SP_FLASH, {z_page, LAST_IDX ^ LAST_IDX}, ST_WRITE);
                  end else begin
                    launch(`FSPCU_OP_ERASE_PG, `FSPCU_SP_FLASH, {z_page, LAST_IDX ^ LAST_IDX}, ST_ERASE);
                  end
                end
              end
              `FSPCU_CMD_WRITE_BOOT_PG, `FSPCU_CMD_ERWR_BOOT_PG: begin
                if (!z_boot) begin
                  abort_flag <= 1'b1;
                end else begin
                  cpu_halt <= 1'b1;
                  write_after <= cmd_sel == `FSPCU_CMD_ERWR_BOOT_PG;
                  if (cmd_sel == `FSPCU_CMD_WRITE_BOOT_PG) begin
                    launch(`FSPCU_OP_WRITE, `FSPCU_SP_FLASH, {z_page, LAST_IDX ^ LAST_IDX}, ST_WRITE);
                  end else begin
                    launch(`FSPCU_OP_ERASE_PG, `FSPCU_SP_FLASH, {z_page, LAST_IDX ^ LAST_IDX}, ST_ERASE);
                  end
                end
              end
              `FSPCU_CMD_ERASE_APP: begin
                cpu_halt <= 1'b1;
                launch(`FSPCU_OP_ERASE_APP, `FSPCU_SP_FLASH, {(ADDR_W-1){1'b0}}, ST_ERASE);
              end
              `FSPCU_CMD_ERASE_USIG: begin
                cpu_halt <= 1'b1;
                launch(`FSPCU_OP_ERASE_SIG, `FSPCU_SP_USER, {(ADDR_W-1){1'b0}}, ST_ERASE);
              end
              `FSPCU_CMD_WRITE_USIG: begin
                cpu_halt <= 1'b1;
                op_page <= {PAGE_W{1'b0}};
                post_clear <= 1'b1;
                launch(`FSPCU_OP_WRITE, `FSPCU_SP_USER, {(ADDR_W-1){1'b0}}, ST_WRITE);
              end
              default: begin
                state <= ST_IDLE;
              end
            endcase
          end else if (exec_go) begin
            crc_val <= `FSPCU_CRC_INIT;
            range_lock <= 1'b0;
            case (cmd_sel)
              `FSPCU_CMD_CLEAR_BUF: begin
                state <= ST_CLEAR;
              end
              `FSPCU_CMD_APPLICATION_CHECKSUM_CMD: begin
                cpu_halt <= 1'b1;
                crc_end <= BOOT_WORD - 1'b1;
                launch(`FSPCU_OP_READ, `FSPCU_SP_FLASH, {(ADDR_W-1){1'b0}}, ST_CRC);
              end
              `FSPCU_CMD_BOOT_CRC: begin
                cpu_halt <= 1'b1;
                crc_end <= TOP_WORD;
                launch(`FSPCU_OP_READ, `FSPCU_SP_FLASH, BOOT_WORD, ST_CRC);
              end
              `FSPCU_CMD_RANGE_CRC: begin
                // Word granular: an odd byte count reads one extra byte
                if (boot_lock_programmed && nvm_addr[ADDR_W-1:1] >= BOOT_WORD) begin
                  abort_flag <= 1'b1;
                end else begin
                  cpu_halt <= 1'b1;
                  range_lock <= 1'b1;
                  crc_end <= nvm_data[ADDR_W-1:1];
                  launch(`FSPCU_OP_READ, `FSPCU_SP_FLASH, nvm_addr[ADDR_W-1:1], ST_CRC);
                end
              end
              default: begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_READ: begin
          if (fl_done) begin
            byte_read_data <= byte_sel ? fl_rdata[15:8] : fl_rdata[7:0];
            byte_read_valid <= 1'b1;
            finish;
          end
        end
        ST_ERASE: begin
          if (fl_done) begin
            if (write_after) begin
              launch(`FSPCU_OP_WRITE, fl_space, {op_page, LAST_IDX ^ LAST_IDX}, ST_WRITE);
            end else begin
              finish;
            end
          end
        end
        ST_WRITE: begin
          if (fl_done) begin
            if (widx == LAST_IDX) begin
              if (post_clear) begin
                // Buffer is cleared after the row write with the core running
                fl_valid <= 1'b0;
                cpu_halt <= 1'b0;
                state <= ST_POSTCLR;
              end else begin
                finish;
              end
            end else begin
              widx <= widx_next;
              fl_addr <= {op_page, widx_next};
              fl_wdata <= buf_flat[widx_next*16 +: 16];
            end
          end
        end
        ST_CRC: begin
          if (fl_done) begin
            if (fl_addr == crc_end) begin
              nvm_data <= {8'h00, crc16_word(crc_val, fl_rdata)};
              finish;
            end else if (range_lock && boot_lock_programmed && crc_next >= BOOT_WORD) begin
              abort_flag <= 1'b1;
              finish;
            end else begin
              crc_val <= crc16_word(crc_val, fl_rdata);
              fl_addr <= crc_next;
            end
          end
        end
        ST_CLEAR, ST_POSTCLR: begin
          finish;
        end
        default: begin
          finish;
        end
      endcase
    end
  end

endmodule

// ===== test/fspcu_sva.sv
/*
 Port assertions of the command unit.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
`include "fspcu_regs.vh"
module fspcu_sva #(
  parameter ADDR_W = 16,
  parameter PW_LOG2 = 6,
  parameter BOOT_START_PAGE = 480
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Register bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  // Core side
  input wire [ADDR_W-1:0] z_pointer,
  input wire program_memory_byte_read,
  input wire program_memory_store,
  input wire [7:0] byte_read_data,
  input wire byte_read_valid,
  input wire cpu_halt,
  input wire nvm_busy,
  input wire flash_section_busy,
  input wire app_access_blocked,
  // Array port
  input wire fl_valid,
  input wire [2:0] fl_op,
  input wire [1:0] fl_space,
  input wire [ADDR_W-2:0] fl_addr,
  input wire fl_done,
  input wire [15:0] fl_rdata
);
  reg [6:0] cmd_q;
  reg rd_pend;
  reg zsel;
  // Command and pending byte-read shadows, not visible at ports
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_q <= 7'h00;
      rd_pend <= 1'b0;
      zsel <= 1'b0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == `FSPCU_OFS_CMD && avs_byteenable[0])
        cmd_q <= avs_writedata[6:0];
      if (program_memory_byte_read && !nvm_busy && !fl_valid) begin
        rd_pend <= 1'b1;
        zsel <= z_pointer[0];
      end else if (byte_read_valid)
        rd_pend <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_wait_once: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("long wait");
  chk_wait_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("idle wait");
  chk_load_quiet: assert property (program_memory_store && cmd_q == `FSPCU_CMD_LOAD_BUF && !nvm_busy
    |=> (!nvm_busy && !fl_valid) [*2])
    else $error("load busy");
  chk_read_issue: assert property (program_memory_byte_read && !nvm_busy && !fl_valid
    |=> fl_valid && fl_op == `FSPCU_OP_READ && fl_addr == $past(z_pointer[ADDR_W-1:1])
    && fl_space == (($past(cmd_q) == 7'h01) ? 2'h1 : ($past(cmd_q) == 7'h02) ? 2'h2 : 2'h0))
    else $error("bad read access");
  chk_byte_pick: assert property (rd_pend && fl_done |=> byte_read_valid
    && byte_read_data == (zsel ? $past(fl_rdata[15:8]) : $past(fl_rdata[7:0])))
    else $error("wrong byte");
  chk_flash_section_busy_op: assert property (fl_valid && (fl_op == `FSPCU_OP_WRITE || fl_op == `FSPCU_OP_ERASE_PG)
    && fl_space == `FSPCU_SP_FLASH |-> nvm_busy && flash_section_busy && app_access_blocked)
    else $error("flags low");
  chk_boot_halt: assert property (fl_valid && $past(fl_valid) && fl_space == `FSPCU_SP_FLASH
    && fl_op != `FSPCU_OP_READ && fl_addr[ADDR_W-2:PW_LOG2] >= BOOT_START_PAGE |-> cpu_halt)
    else $error("boot no halt");
  chk_app_nohalt: assert property (nvm_busy && (cmd_q == `FSPCU_CMD_ERASE_APP_PG || cmd_q == `FSPCU_CMD_WRITE_APP_PG
    || cmd_q == `FSPCU_CMD_ERWR_APP_PG || cmd_q == `FSPCU_CMD_CLEAR_BUF) |-> !cpu_halt)
    else $error("app halted");
  chk_clear_short: assert property (nvm_busy && cmd_q == `FSPCU_CMD_CLEAR_BUF |=> !nvm_busy)
    else $error("clear long");
  chk_crc_halt: assert property (fl_valid && $past(fl_valid) && (cmd_q == `FSPCU_CMD_APPLICATION_CHECKSUM_CMD
    || cmd_q == `FSPCU_CMD_BOOT_CRC || cmd_q == `FSPCU_CMD_RANGE_CRC) |-> cpu_halt && nvm_busy)
    else $error("crc no halt");
  cover property (byte_read_valid);
  cover property ($rose(cpu_halt));
  cover property (fl_done && fl_op == `FSPCU_OP_WRITE);
endmodule
bind fspcu_top fspcu_sva #(.ADDR_W(ADDR_W), .PW_LOG2(PW_LOG2), .BOOT_START_PAGE(BOOT_START_PAGE)) i_sva (.*);

// ===== test/fspcu_flash_model.sv
/*
 Flash array model.
 Assumes one operation at a time, held until fl_done.
*/
`timescale 1ns/1ps
`include "fspcu_regs.vh"
module fspcu_flash_model #(
  parameter BOOT_START_PAGE = 480
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Array port
  input wire fl_valid,
  input wire [2:0] fl_op,
  input wire [1:0] fl_space,
  input wire [14:0] fl_addr,
  input wire [15:0] fl_wdata,
  output reg fl_done,
  output reg [15:0] fl_rdata,
  // Bench control
  input wire slow
);
  logic [15:0] mem [int];
  int cnt = 0;
  int k;
  function automatic logic [15:0] peek(input int key);
    return mem.exists(key) ? mem[key] : `FSPCU_ERASED;
  endfunction
  initial begin
    fl_done = 1'b0;
    fl_rdata = 16'h0000;
  end
  always @(posedge clk_sys) begin
    k = {fl_space, fl_addr};
    fl_done <= 1'b0;
    // Read data is good only in the done cycle
    fl_rdata <= ~fl_rdata;
    if (!rst_n || !fl_valid || fl_done)
      cnt = 0;
    else if (cnt == (slow ? 3 : 0)) begin
      cnt = 0;
      fl_done <= 1'b1;
      case (fl_op)
        `FSPCU_OP_READ: fl_rdata <= peek(k);
        `FSPCU_OP_WRITE: mem[k] = fl_wdata;
        `FSPCU_OP_ERASE_PG: for (int i = 0; i < 64; i++) mem.delete({fl_space, fl_addr[14:6], i[5:0]});
        `FSPCU_OP_ERASE_APP: for (int i = 0; i < BOOT_START_PAGE * 64; i++) mem.delete(i);
        `FSPCU_OP_ERASE_SIG: for (int i = 0; i < 64; i++) mem.delete(32768 + i);
        default: ;
      endcase
    end else
      cnt = cnt + 1;
  end
endmodule

// ===== test/flash_self_program_cmd_unit_tb_top.sv
/*
 Bench: Avalon master, core driver, flash model, reference memory.
 Assumes every bus request is answered.
*/
`timescale 1ns/1ps
`include "fspcu_regs.vh"
module flash_self_program_cmd_unit_tb_top;
  localparam BOOT = 500;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] avs_address = 8'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [3:0] avs_byteenable = 4'h0;
  reg [31:0] avs_writedata = 32'h0000_0000;
  reg [15:0] z_pointer = 16'h0000;
  reg [15:0] word_data_registers = 16'h0000;
  reg program_memory_byte_read = 1'b0;
  reg program_memory_store = 1'b0;
  reg boot_lock_programmed = 1'b0;
  reg slow = 1'b0;
  wire [31:0] avs_readdata;
  wire [7:0] byte_read_data;
  wire [2:0] fl_op;
  wire [1:0] fl_space;
  wire [14:0] fl_addr;
  wire [15:0] fl_wdata, fl_rdata;
  wire avs_waitrequest, byte_read_valid, cpu_halt, nvm_busy, flash_section_busy, app_access_blocked, fl_valid, fl_done;
  int err_total = 0;
  int compares = 0;
  int seed = 7;
  int ref_m [int];
  int buf_m [64];
  int tc [12] = '{'h2E, 'h2F, 'h2B, 'h25, 'h2D, 'h22, 'h24, 'h2C, 'h1A, 'h2B, 'h20, 'h18};
  int tp [12] = '{10, 505, 10, 20, 506, 20, 30, 507, -1, 505, 30, -1};
  int th [12] = '{0, 1, 0, 0, 1, 0, 0, 1, 1, 1, 1, 1};
  int tk [12] = '{0, 1, 2, 1, 1, 2, 0, 0, 0, 2, 3, 4};
  reg [31:0] rd;
  reg [15:0] z;
  int n, k;
  always #4 clk_sys = ~clk_sys;
  fspcu_top #(.BOOT_START_PAGE(BOOT), .CCP_WINDOW(4'hF)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .z_pointer(z_pointer), .word_data_registers(word_data_registers),
    .program_memory_byte_read(program_memory_byte_read), .program_memory_store(program_memory_store),
    .boot_lock_programmed(boot_lock_programmed), .byte_read_data(byte_read_data),
    .byte_read_valid(byte_read_valid), .cpu_halt(cpu_halt), .nvm_busy(nvm_busy),
    .flash_section_busy(flash_section_busy), .app_access_blocked(app_access_blocked), .fl_valid(fl_valid),
    .fl_op(fl_op), .fl_space(fl_space), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_done(fl_done),
    .fl_rdata(fl_rdata));
  fspcu_flash_model #(.BOOT_START_PAGE(BOOT)) i_mem (.clk_sys(clk_sys), .rst_n(rst_n), .fl_valid(fl_valid),
    .fl_op(fl_op), .fl_space(fl_space), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_done(fl_done),
    .fl_rdata(fl_rdata), .slow(slow));
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic give_up(input bit hung);
    if (hung) begin
      err_total++;
      complete_run;
    end
  endtask
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hF;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    give_up(n >= 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic core(input bit is_rd, input logic [15:0] zp, input logic [15:0] d);
    @(posedge clk_sys);
    z_pointer <= zp;
    word_data_registers <= d;
    program_memory_byte_read <= is_rd;
    program_memory_store <= !is_rd;
    @(posedge clk_sys);
    program_memory_byte_read <= 1'b0;
    program_memory_store <= 1'b0;
    z_pointer <= $random(seed);
  endtask
  task automatic wait_idle(input logic hlt);
    logic seen = 1'b0, rv = 1'b0;
    for (n = 0; n < 30000 && (n == 0 || nvm_busy !== 1'b0); n++) begin
      @(negedge clk_sys);
      seen |= (cpu_halt === 1'b1);
      rv |= (byte_read_valid === 1'b1);
    end
    give_up(n >= 30000);
    chk(seen, hlt);
    chk(rv, 1'b0);
  endtask
  task automatic prot_exec(input logic [6:0] c);
    bus(1, `FSPCU_OFS_CMD, c);
    bus(1, `FSPCU_OFS_CCP, `FSPCU_CCP_KEY);
    bus(1, `FSPCU_OFS_CTRLA, 32'h0000_0001);
  endtask
  function automatic logic [15:0] ref_val(input int a);
    return ref_m.exists(a) ? ref_m[a] : 16'hFFFF;
  endfunction
  function automatic logic [15:0] crc_ref(input int lo, input int hi);
    logic [15:0] c;
    logic [15:0] w;
    c = `FSPCU_CRC_INIT;
    for (int a = lo; a <= hi; a++) begin
      w = ref_val(a);
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? `FSPCU_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic commit(input int i);
    int base;
    base = (tp[i] < 0) ? 32768 : tp[i] * 64;
    if (tk[i] < 2) begin
      prot_exec(`FSPCU_CMD_CLEAR_BUF);
      wait_idle(1'b0);
      for (int w = 0; w < 64; w++) buf_m[w] = 'hFFFF;
      bus(1, `FSPCU_OFS_CMD, `FSPCU_CMD_LOAD_BUF);
      repeat (8) begin
        k = $random(seed) & 63;
        buf_m[k] = $random(seed) & 'hFFFF;
        core(0, 16'(($random(seed) & 'hFF80) | (k << 1)), 16'(buf_m[k]));
      end
    end
    slow <= $random(seed) & 1;
    bus(1, `FSPCU_OFS_CMD, tc[i]);
    bus(1, `FSPCU_OFS_CCP, `FSPCU_CCP_KEY);
    core(0, 16'((tp[i] < 0 ? 0 : tp[i] * 128) + ($random(seed) & 127)), 16'h0000);
    if (tc[i] == 'h2F)
      core(1, 16'h0000, 16'h0000);
    wait_idle(th[i]);
    for (int w = 0; w < 64; w++) begin
      if (tk[i] < 2)
        ref_m[base + w] = buf_m[w];
      else
        ref_m.delete(base + w);
    end
    if (tk[i] == 3)
      for (int a = 0; a < BOOT * 64; a++) ref_m.delete(a);
    for (int w = 0; w < 64; w++) chk(i_mem.peek(base + w), ref_val(base + w));
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(0, `FSPCU_OFS_STATUS, 0);
    chk(rd, 32'h0000_0000);
    bus(0, 8'h40, 0);
    chk(rd, 32'h0000_0000);
    chk(fl_wdata, 16'hFFFF);
    for (int i = 0; i < 12; i++) commit(i);
    for (int i = 0; i < 8; i++) begin
      z = $random(seed);
      k = (i % 4 == 3 ? 0 : i % 4) * 32768 + z[15:1];
      ref_m[k] = $random(seed) & 'hFFFF;
      i_mem.mem[k] = ref_m[k];
      bus(1, `FSPCU_OFS_CMD, i % 4 == 3 ? 7'h05 : i % 4);
      core(1, z, 16'h0000);
      for (n = 0; n < 20 && byte_read_valid !== 1'b1; n++) @(negedge clk_sys);
      give_up(n >= 20);
      chk(byte_read_data, z[0] ? ref_m[k][15:8] : ref_m[k][7:0]);
    end
    k = 2 * (100 + ($random(seed) & 63));
    bus(1, `FSPCU_OFS_ADDR, k + 1);
    bus(1, `FSPCU_OFS_DATA, k + 40);
    prot_exec(`FSPCU_CMD_RANGE_CRC);
    wait_idle(1'b1);
    bus(0, `FSPCU_OFS_DATA, 0);
    chk(rd, {16'h0000, crc_ref(k / 2, (k + 40) / 2)});
    prot_exec(`FSPCU_CMD_BOOT_CRC);
    wait_idle(1'b1);
    bus(0, `FSPCU_OFS_DATA, 0);
    chk(rd, {16'h0000, crc_ref(BOOT * 64, 32767)});
    boot_lock_programmed <= 1'b1;
    bus(1, `FSPCU_OFS_ADDR, BOOT * 128);
    bus(1, `FSPCU_OFS_DATA, BOOT * 128 + 20);
    prot_exec(`FSPCU_CMD_RANGE_CRC);
    wait_idle(1'b0);
    bus(0, `FSPCU_OFS_STATUS, 0);
    chk(rd[2:0], 3'h4);
    bus(1, `FSPCU_OFS_STATUS, 32'h0000_0004);
    bus(0, `FSPCU_OFS_STATUS, 0);
    chk(rd[2:0], 3'h0);
    complete_run;
  end
endmodule
